// File: inc/scmc_consts.svh
// Constants for the system clock mode control block: offsets, fields, resets.
// Assumes an APB slave with 32-bit data; each register is one aligned word.
// Notes on behaviour
// - Pin-pair select routes pins main or sub
// - Wait stop bit gates peripheral clock
// - Sub clock runs unless its stop set
// - Sub pin enable sets, never clears
// - Main pin enable sets, never clears
// - Main stop halts oscillator, buffer only externally; code always halts the buffer together with the oscillator
// - Pins free when main stopped, unpinned
// - Divide-by-8 override, else two-bit field
// - Stop entry forces divide-by-8 select
// - All-clock stop halts clocks, resistors off; code leaves the high-speed on-chip oscillator enable as it was
// - Feedback resistor bits: zero on, one off
// - Low-speed stop only with main clock
// - Wait stops CPU clock, oscillators run
// - Interrupt ends wait and clears wait bit
// - No-div exit bit clears division on wait
// - Exit field 10 selects high-speed on-chip
// - Exit field 11 starts and selects main
// - Monitor shows main stop, zero when disabled
// - Detected stop with interrupt enabled forces on-chip select
// - Writes need protect-0 enable set first
`ifndef SCMC_CONSTS_SVH
`define SCMC_CONSTS_SVH

//--------------------------------------------------------------
// Register indices and byte addresses
//--------------------------------------------------------------
`define SCMC_IDX_CTRL0   12'h006
`define SCMC_IDX_CTRL1   12'h007
`define SCMC_IDX_CTRL3   12'h009
`define SCMC_IDX_OSD     12'h00C
`define SCMC_IDX_PROT    12'h00A
`define SCMC_ADDR(i)     ((i) << 2)

//--------------------------------------------------------------
// Reset values
//--------------------------------------------------------------
`define SCMC_RST_CTRL0   8'h28
`define SCMC_RST_CTRL1   8'h20
`define SCMC_RST_CTRL3   8'h00
`define SCMC_RST_OSD     8'h04
`define SCMC_RST_PROT    8'h00

//--------------------------------------------------------------
// Field positions
//--------------------------------------------------------------
`define SCMC_C0_PINSEL   1
`define SCMC_C0_WPSTOP   2
`define SCMC_C0_SUBSTOP  3
`define SCMC_C0_SUBPIN   4
`define SCMC_C0_MAINSTOP 5
`define SCMC_C0_DIV8     6
`define SCMC_C0_SUBSEL   7
`define SCMC_C1_ALLSTOP  0
`define SCMC_C1_MFBOFF   1
`define SCMC_C1_SFBOFF   2
`define SCMC_C1_MAINPIN  3
`define SCMC_C1_LSSTOP   4
`define SCMC_C1_RSV1     5
`define SCMC_C3_WAIT     0
`define SCMC_C3_NODIV    5
`define SCMC_OSD_EN      0
`define SCMC_OSD_IRQEN   1
`define SCMC_OSD_SYSSEL  2
`define SCMC_OSD_MON     3
`define SCMC_PROT_P0     0

//--------------------------------------------------------------
// Field codes
//--------------------------------------------------------------
`define SCMC_DIV_NONE    2'h0
`define SCMC_DIV_2       2'h1
`define SCMC_DIV_4       2'h2
`define SCMC_DIV_16      2'h3
`define SCMC_EXIT_KEEP   2'h0
`define SCMC_EXIT_HS     2'h2
`define SCMC_EXIT_MAIN   2'h3
`define SCMC_OSD_BOTH    2'h3
`define SCMC_OSD_NONE    2'h0
`define SCMC_RATIO_1     5'h01
`define SCMC_RATIO_2     5'h02
`define SCMC_RATIO_4     5'h04
`define SCMC_RATIO_8     5'h08
`define SCMC_RATIO_16    5'h10

`endif

// File: inc/scmc_pkg.sv
// Types for the system clock mode control block.
// Assumes the constants header is compiled alongside.
package scmc_pkg;

   //--------------------------------------------------------------
   // Mode of the block
   //--------------------------------------------------------------
   typedef enum logic [2:0] {
      SCMC_RUN  = 3'b001,
      SCMC_WAIT = 3'b010,
      SCMC_STOP = 3'b100
   } scmc_mode_t;

   // Clock and pin controls sent to the oscillators and pads.
   typedef struct packed {
      logic       main_osc_run;
      logic       main_buf_run;
      logic       sub_osc_run;
      logic       main_fb_on;
      logic       sub_fb_on;
      logic       pins_to_sub;
      logic       pins_gpio;
      logic       low_speed_osc_run;
      logic       cpu_clk_run;
      logic       periph_clk_run;
      logic       use_sub_clk;
      logic       use_onchip_clk;
      logic       hs_osc_enable;
      logic       hs_osc_select;
      logic [4:0] cpu_div_ratio;
   } scmc_ctl_t;

   // Whole state of the block.
   typedef struct packed {
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] ctrl3;
      logic [7:0] osd;
      logic [7:0] prot;
      logic       hs_en;
      logic       hs_sel;
      scmc_mode_t mode;
      logic [31:0] prdata;
   } scmc_state_t;

endpackage

// File: rtl/scmc_top.sv
// System clock mode control: clock source, divider, wait/stop and stop detect.
// Assumes an APB master on pclk and oscillator status as synchronous levels.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scmc_consts.svh"

module scmc_top (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // System events
   input  wire logic              periph_irq,
   input  wire logic              main_osc_stopped,
   // Control outputs
   output scmc_pkg::scmc_ctl_t    ctl,
   output logic [2:0]             mode_state
);

   //--------------------------------------------------------------
   // State
   //--------------------------------------------------------------
   scmc_pkg::scmc_state_t st_r;
   scmc_pkg::scmc_state_t st_nxt;

   logic       wr;
   logic       rd;
   logic       p0;
   logic [7:0] wb;
   logic       mapped;
   logic       mon;

   // Zero-wait-state access: answer in the access phase at once.
   assign pready  = 1'b1;
   assign wr      = psel & penable & pwrite & pstrb[0];
   assign rd      = psel & ~penable & ~pwrite;
   assign wb      = pwdata[7:0];
   assign p0      = st_r.prot[`SCMC_PROT_P0];
   assign prdata  = st_r.prdata;
   assign mapped  = (paddr == 12'(`SCMC_ADDR(`SCMC_IDX_CTRL0))) |
                    (paddr == 12'(`SCMC_ADDR(`SCMC_IDX_CTRL1))) |
                    (paddr == 12'(`SCMC_ADDR(`SCMC_IDX_CTRL3))) |
                    (paddr == 12'(`SCMC_ADDR(`SCMC_IDX_OSD)))   |
                    (paddr == 12'(`SCMC_ADDR(`SCMC_IDX_PROT)));
   assign pslverr = psel & penable & ~mapped;
   assign mode_state = st_r.mode;

   // Monitor only reports while detection is enabled.
   assign mon = st_r.osd[`SCMC_OSD_EN] & main_osc_stopped;

   //--------------------------------------------------------------
   // Next state: register writes, mode entry and exit, hardware sets
   //--------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // Register writes; hardware updates below win over them.
      if (wr && paddr == 12'(`SCMC_ADDR(`SCMC_IDX_PROT))) begin
         st_nxt.prot = {7'h00, wb[`SCMC_PROT_P0]};
      end
      if (wr && p0) begin
         case (paddr)
            12'(`SCMC_ADDR(`SCMC_IDX_CTRL0)): begin
               st_nxt.ctrl0 = {wb[7:1], 1'b0};
               // Pin enable is sticky once set.
               st_nxt.ctrl0[`SCMC_C0_SUBPIN] = wb[`SCMC_C0_SUBPIN] |
                                               st_r.ctrl0[`SCMC_C0_SUBPIN];
            end
            12'(`SCMC_ADDR(`SCMC_IDX_CTRL1)): begin
               st_nxt.ctrl1 = wb;
               st_nxt.ctrl1[`SCMC_C1_RSV1] = 1'b1;
               st_nxt.ctrl1[`SCMC_C1_MAINPIN] = wb[`SCMC_C1_MAINPIN] |
                                                st_r.ctrl1[`SCMC_C1_MAINPIN];
            end
            12'(`SCMC_ADDR(`SCMC_IDX_CTRL3)): begin
               st_nxt.ctrl3 = {wb[7:5], 4'h0, wb[`SCMC_C3_WAIT]};
            end
            12'(`SCMC_ADDR(`SCMC_IDX_OSD)): begin
               st_nxt.osd[1:0] = wb[1:0];
               // A detected stop blocks a return to the main clock.
               st_nxt.osd[`SCMC_OSD_SYSSEL] = wb[`SCMC_OSD_SYSSEL] | mon;
            end
            default: begin
               st_nxt.prot = st_nxt.prot;
            end
         endcase
      end
      // Automatic fail-over to the on-chip oscillator.
      if (st_r.osd[1:0] == `SCMC_OSD_BOTH && main_osc_stopped) begin
         st_nxt.osd[`SCMC_OSD_SYSSEL] = 1'b1;
      end
      // Low-speed stop is held clear while on-chip clock is selected.
      if (st_nxt.osd[`SCMC_OSD_SYSSEL]) begin
         st_nxt.ctrl1[`SCMC_C1_LSSTOP] = 1'b0;
      end
      // Mode sequencing.
      case (st_r.mode)
         scmc_pkg::SCMC_RUN: begin
            if (st_nxt.ctrl1[`SCMC_C1_ALLSTOP]) begin
               st_nxt.mode = scmc_pkg::SCMC_STOP;
               st_nxt.ctrl0[`SCMC_C0_DIV8] = 1'b1;
            end else if (st_nxt.ctrl3[`SCMC_C3_WAIT]) begin
               st_nxt.mode = scmc_pkg::SCMC_WAIT;
               if (st_nxt.ctrl3[`SCMC_C3_NODIV]) begin
                  st_nxt.ctrl0[`SCMC_C0_DIV8] = 1'b0;
                  st_nxt.ctrl1[7:6] = `SCMC_DIV_NONE;
               end
            end
         end
         scmc_pkg::SCMC_WAIT, scmc_pkg::SCMC_STOP: begin
            if (periph_irq) begin
               st_nxt.mode = scmc_pkg::SCMC_RUN;
               st_nxt.ctrl3[`SCMC_C3_WAIT] = 1'b0;
               st_nxt.ctrl1[`SCMC_C1_ALLSTOP] = 1'b0;
               case (st_r.ctrl3[7:6])
                  `SCMC_EXIT_HS: begin
                     st_nxt.osd[`SCMC_OSD_SYSSEL] = 1'b1;
                     st_nxt.ctrl1[`SCMC_C1_LSSTOP] = 1'b0;
                     st_nxt.hs_en  = 1'b1;
                     st_nxt.hs_sel = 1'b1;
                  end
                  `SCMC_EXIT_MAIN: begin
                     st_nxt.ctrl0[`SCMC_C0_MAINSTOP] = 1'b0;
                     st_nxt.ctrl1[`SCMC_C1_MAINPIN] = 1'b1;
                     st_nxt.osd[`SCMC_OSD_SYSSEL] = mon;
                  end
                  default: begin
                     st_nxt.hs_en = st_r.hs_en;
                  end
               endcase
            end
         end
         default: begin
            st_nxt.mode = scmc_pkg::SCMC_RUN;
         end
      endcase
      // Monitor bit is read-only and mirrors detection.
      st_nxt.osd[`SCMC_OSD_MON] = mon;
      st_nxt.osd[7:4] = 4'h0;
      // Read data is captured in the setup phase.
      st_nxt.prdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            12'(`SCMC_ADDR(`SCMC_IDX_CTRL0)): st_nxt.prdata = {24'h0, st_r.ctrl0};
            12'(`SCMC_ADDR(`SCMC_IDX_CTRL1)): st_nxt.prdata = {24'h0, st_r.ctrl1};
            12'(`SCMC_ADDR(`SCMC_IDX_CTRL3)): st_nxt.prdata = {24'h0, st_r.ctrl3};
            12'(`SCMC_ADDR(`SCMC_IDX_OSD)):   st_nxt.prdata = {24'h0, st_r.osd};
            12'(`SCMC_ADDR(`SCMC_IDX_PROT)):  st_nxt.prdata = {24'h0, st_r.prot};
            default:                          st_nxt.prdata = 32'h0000_0000;
         endcase
      end else if (psel & penable) begin
         st_nxt.prdata = st_r.prdata;
      end
   end

   //--------------------------------------------------------------
   // State register
   //--------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.ctrl0  <= `SCMC_RST_CTRL0;
         st_r.ctrl1  <= `SCMC_RST_CTRL1;
         st_r.ctrl3  <= `SCMC_RST_CTRL3;
         st_r.osd    <= `SCMC_RST_OSD;
         st_r.prot   <= `SCMC_RST_PROT;
         st_r.hs_en  <= 1'b0;
         st_r.hs_sel <= 1'b0;
         st_r.mode   <= scmc_pkg::SCMC_RUN;
         st_r.prdata <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
      end
   end

   //--------------------------------------------------------------
   // Clock and pin control decode
   //--------------------------------------------------------------
   logic stop_m;
   logic wait_m;
   assign stop_m = st_r.mode == scmc_pkg::SCMC_STOP;
   assign wait_m = st_r.mode == scmc_pkg::SCMC_WAIT;

   always_comb begin
      ctl = '0;
      // Main stop or stop mode halts the oscillator and its buffer together.
      ctl.main_osc_run = ~st_r.ctrl0[`SCMC_C0_MAINSTOP] & ~stop_m;
      ctl.main_buf_run = ctl.main_osc_run;
      ctl.sub_osc_run  = ~st_r.ctrl0[`SCMC_C0_SUBSTOP] & ~stop_m;
      // Stop mode disables both feedback resistors.
      ctl.main_fb_on   = ~st_r.ctrl1[`SCMC_C1_MFBOFF] & ~stop_m;
      ctl.sub_fb_on    = ~st_r.ctrl1[`SCMC_C1_SFBOFF] & ~stop_m;
      ctl.pins_to_sub  = st_r.ctrl0[`SCMC_C0_PINSEL];
      ctl.pins_gpio    = st_r.ctrl0[`SCMC_C0_MAINSTOP] &
                         ~st_r.ctrl1[`SCMC_C1_MAINPIN];
      ctl.low_speed_osc_run = ~st_r.ctrl1[`SCMC_C1_LSSTOP] & ~stop_m;
      // Oscillators keep running in wait so peripherals continue unless the wait stop bit is set.
      ctl.cpu_clk_run    = ~wait_m & ~stop_m;
      ctl.periph_clk_run = ~stop_m & ~(wait_m & st_r.ctrl0[`SCMC_C0_WPSTOP]);
      // Sub selection is only safe after the sub pins are enabled.
      ctl.use_sub_clk    = st_r.ctrl0[`SCMC_C0_SUBSEL];
      ctl.use_onchip_clk = st_r.osd[`SCMC_OSD_SYSSEL];
      ctl.hs_osc_enable  = st_r.hs_en;
      ctl.hs_osc_select  = st_r.hs_sel;
      if (st_r.ctrl0[`SCMC_C0_DIV8]) begin
         ctl.cpu_div_ratio = `SCMC_RATIO_8;
      end else begin
         case (st_r.ctrl1[7:6])
            `SCMC_DIV_NONE: ctl.cpu_div_ratio = `SCMC_RATIO_1;
            `SCMC_DIV_2:    ctl.cpu_div_ratio = `SCMC_RATIO_2;
            `SCMC_DIV_4:    ctl.cpu_div_ratio = `SCMC_RATIO_4;
            default:        ctl.cpu_div_ratio = `SCMC_RATIO_16;
         endcase
      end
   end

endmodule
`default_nettype wire

// File: tb/scmc_chk.sv
// Checker for the system clock mode control block, watching its ports only.
// Assumes one clock domain on pclk with presetn as its reset.
`timescale 1ns/1ps
`default_nettype none

module scmc_chk (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // Events and controls
   input wire logic                periph_irq,
   input wire scmc_pkg::scmc_ctl_t ctl,
   input wire logic [2:0]          mode_state
);
   //----------------------------------------
   // Mode and clock relations
   //----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_stop_div;
      mode_state == 3'b100 |-> ctl.cpu_div_ratio == 5'h08;
   endproperty
   a_stop_div: assert property (p_stop_div) else $error("stop without divide by 8");

   property p_stop_fb;
      mode_state == 3'b100 |-> !ctl.main_fb_on && !ctl.sub_fb_on;
   endproperty
   a_stop_fb: assert property (p_stop_fb) else $error("resistor on in stop");

   property p_stop_clk;
      mode_state == 3'b100 |-> !(ctl.cpu_clk_run | ctl.periph_clk_run | ctl.sub_osc_run);
   endproperty
   a_stop_clk: assert property (p_stop_clk) else $error("clock runs in stop");

   property p_wait_cpu;
      mode_state == 3'b010 |-> !ctl.cpu_clk_run;
   endproperty
   a_wait_cpu: assert property (p_wait_cpu) else $error("cpu clock in wait");

   // Oscillators must not be touched merely because the block sits in wait.
   property p_wait_osc;
      mode_state == 3'b010 ##1 mode_state == 3'b010 |-> $stable(ctl.main_osc_run)
         && $stable(ctl.sub_osc_run);
   endproperty
   a_wait_osc: assert property (p_wait_osc) else $error("oscillator moved in wait");

   property p_wake;
      mode_state != 3'b001 && periph_irq |=> mode_state == 3'b001;
   endproperty
   a_wake: assert property (p_wake) else $error("interrupt did not end the mode");

   property p_gpio;
      ctl.pins_gpio |-> !ctl.main_osc_run;
   endproperty
   a_gpio: assert property (p_gpio) else $error("pins free while main runs");

   property p_lowspd;
      ctl.use_onchip_clk && mode_state != 3'b100 |-> ctl.low_speed_osc_run;
   endproperty
   a_lowspd: assert property (p_lowspd) else $error("low speed off on chip clock");
endmodule

`default_nettype wire

// File: tb/scmc_partner.sv
// Model of the interrupt source and main oscillator beside the block.
// Assumes the bench commands wake-ups and oscillator failures.
`timescale 1ns/1ps
`default_nettype none

module scmc_partner #(
   parameter int DLY = 3
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Commands from the bench
   input  wire logic       wake_req,
   input  wire logic       osc_fail,
   input  wire logic [2:0] mode_state,
   // Towards the block
   output logic            periph_irq,
   output logic            main_osc_stopped
);
   int cnt;

   // Interrupts are masked until the block sleeps, so a request only appears later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt        <= 0;
         periph_irq <= 1'b0;
      end else begin
         cnt        <= (wake_req && mode_state != 3'b001) ? cnt + 1 : 0;
         periph_irq <= wake_req && mode_state != 3'b001 && cnt >= DLY;
      end
   end

   assign main_osc_stopped = osc_fail;
endmodule

`default_nettype wire

// File: tb/tb_system_clock_mode_control.sv
// Directed bench for the clock mode control block over APB.
// Assumes the design, its package and header, the checker and the partner.
`timescale 1ns/1ps
`default_nettype none
`include "scmc_consts.svh"

module tb_system_clock_mode_control;
   localparam logic [11:0] A0 = `SCMC_ADDR(`SCMC_IDX_CTRL0);
   localparam logic [11:0] A1 = `SCMC_ADDR(`SCMC_IDX_CTRL1);
   localparam logic [11:0] A3 = `SCMC_ADDR(`SCMC_IDX_CTRL3);
   localparam logic [11:0] AO = `SCMC_ADDR(`SCMC_IDX_OSD);
   localparam logic [11:0] AP = `SCMC_ADDR(`SCMC_IDX_PROT);
   logic [4:0] ratio [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic wake_req = 1'b0, osc_fail = 1'b0, pready, pslverr, periph_irq, main_osc_stopped, rerr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0]  pstrb = 4'hF;
   logic [2:0]  mode_state;
   scmc_pkg::scmc_ctl_t ctl;
   int mismatches = 0, num_checks = 0, cycles = 0;

   scmc_top scmc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .periph_irq(periph_irq),
      .main_osc_stopped(main_osc_stopped), .ctl(ctl), .mode_state(mode_state));
   scmc_partner scmc_partner_i (.pclk(pclk), .presetn(presetn), .wake_req(wake_req),
      .osc_fail(osc_fail), .mode_state(mode_state), .periph_irq(periph_irq),
      .main_osc_stopped(main_osc_stopped));

   //----------------------------------------
   // Clock, timeout and reporting
   //----------------------------------------
   always #2.5 pclk = ~pclk;

   // A hang shows up as a mismatch rather than a silent stall.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Single bits are taken when the task is called and compared at the following falling edge.
   task automatic chkb(input logic got, input logic exp);
      @(negedge pclk);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   //----------------------------------------
   // APB master
   //----------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] q);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Answer and read data are taken at the rising edge that completes the access.
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q    = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Callers look at outputs only once this edge's updates have landed.
      @(negedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 8'h00, q);
      chk(q, {24'h0, e});
   endtask

   task automatic enter(input logic [11:0] a, input logic [7:0] d, input logic [2:0] m);
      wr(a, d);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({29'h0, mode_state}, {29'h0, m});
   endtask

   task automatic wake();
      int n;
      @(posedge pclk);
      wake_req <= 1'b1;
      n = 0;
      while (mode_state !== 3'b001 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      wake_req <= 1'b0;
      chkb(mode_state == 3'b001, 1'b1);
   endtask

   //----------------------------------------
   // Tests
   //----------------------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(A0, 8'h28);
      rd(A1, 8'h20);
      rd(A3, 8'h00);
      rd(AO, 8'h04);
      rd(12'h000, 8'h00);
      chkb(rerr, 1'b1);
      wr(A0, 8'hFF);
      rd(A0, 8'h28);
      $display("test 1 done");
      wr(AP, 8'h01);
      wr(A0, 8'h3A);
      chkb(ctl.pins_to_sub, 1'b1);
      chkb(ctl.sub_osc_run, 1'b0);
      wr(A0, 8'h20);
      rd(A0, 8'h30);
      chkb(ctl.sub_osc_run, 1'b1);
      chkb(ctl.pins_gpio, 1'b1);
      chkb(ctl.main_osc_run | ctl.main_buf_run, 1'b0);
      wr(A0, 8'hB0);
      chkb(ctl.use_sub_clk, 1'b1);
      wr(A0, 8'h30);
      wr(A1, 8'h2E);
      chkb(ctl.pins_gpio, 1'b0);
      chkb(ctl.main_fb_on | ctl.sub_fb_on, 1'b0);
      wr(A1, 8'h20);
      rd(A1, 8'h28);
      chkb(ctl.main_fb_on & ctl.sub_fb_on, 1'b1);
      $display("test 2 done");
      for (int k = 0; k < 4; k++) begin
         wr(A1, {k[1:0], 6'h28});
         chkb(ctl.cpu_div_ratio == ratio[k], 1'b1);
      end
      wr(A0, 8'h70);
      chkb(ctl.cpu_div_ratio == 5'h08, 1'b1);
      wr(A1, 8'h38);
      rd(A1, 8'h28);
      chkb(ctl.low_speed_osc_run, 1'b1);
      $display("test 3 done");
      wr(A0, 8'h74);
      enter(A3, 8'h21, 3'b010);
      chkb(ctl.cpu_div_ratio == 5'h01, 1'b1);
      chkb(ctl.periph_clk_run, 1'b0);
      wake();
      rd(A3, 8'h20);
      rd(A0, 8'h34);
      wr(A0, 8'h30);
      enter(A3, 8'h01, 3'b010);
      chkb(ctl.periph_clk_run, 1'b1);
      wake();
      enter(A1, 8'h29, 3'b100);
      wake();
      rd(A0, 8'h70);
      $display("test 4 done");
      enter(A3, 8'h81, 3'b010);
      wake();
      chkb(ctl.hs_osc_enable & ctl.hs_osc_select & ctl.use_onchip_clk, 1'b1);
      enter(A3, 8'hC1, 3'b010);
      wake();
      rd(AO, 8'h00);
      rd(A0, 8'h50);
      chkb(ctl.use_onchip_clk, 1'b0);
      chkb(ctl.main_osc_run & ctl.main_buf_run, 1'b1);
      wr(A1, 8'h38);
      rd(A1, 8'h38);
      chkb(ctl.low_speed_osc_run, 1'b0);
      $display("test 5 done");
      wr(AO, 8'h03);
      rd(AO, 8'h03);
      @(posedge pclk);
      osc_fail <= 1'b1;
      repeat (3) @(posedge pclk);
      rd(AO, 8'h0F);
      rd(A1, 8'h28);
      wr(AO, 8'h03);
      rd(AO, 8'h0F);
      wr(AO, 8'h00);
      rd(AO, 8'h04);
      @(posedge pclk);
      osc_fail <= 1'b0;
      $display("test 6 done");
      final_report();
   end
endmodule

bind scmc_top scmc_chk scmc_chk_i (.pclk(pclk), .presetn(presetn), .periph_irq(periph_irq),
   .ctl(ctl), .mode_state(mode_state));

`default_nettype wire
